// *** src/lnm_mode_ctrl.sv ***
// mode and reset sequencer of a lin slave node with regulator
// assumes analogue indications arrive as digital levels on any timing
`timescale 1ns/1ps
module lnm_mode_ctrl #(
  parameter int unsigned RESET_DELAY = lnm_pkg::RESET_DELAY_CYCLES,
  parameter int unsigned WAKE_TIME = lnm_pkg::WAKE_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // analogue indications, active high
  input wire logic supply_below_on_i,
  input wire logic supply_above_off_i,
  input wire logic out_below_master_reset_i,
  input wire logic out_above_reset_thr_i,
  input wire logic temp_above_shutdown_i,
  input wire logic temp_below_recovery_i,
  // pins
  input wire logic enable_i,
  input wire logic bus_level_i,
  input wire logic transmit_data_in_i,
  // outputs
  output logic regulator_on_o,
  output logic transceiver_on_o,
  output logic bus_drive_dominant_o,
  output logic receive_data_out_o,
  output logic reset_n_o,
  output logic [2:0] mode_o
);
  lnm_cond_if cond ();
  logic [7:0] sync_w;
  logic txd_meta_reg;
  logic txd_reg;

  lnm_sync #(.N(8)) u_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .raw_i({supply_below_on_i, supply_above_off_i, out_below_master_reset_i,
            out_above_reset_thr_i, temp_above_shutdown_i, temp_below_recovery_i,
            enable_i, bus_level_i}),
    .sync_o(sync_w)
  );
  assign cond.supply_low = sync_w[7];
  assign cond.supply_ok = sync_w[6];
  assign cond.master_reset = sync_w[5];
  assign cond.out_above_reset = sync_w[4];
  assign cond.over_temp = sync_w[3];
  assign cond.under_recovery = sync_w[2];
  assign cond.en = sync_w[1];
  assign cond.bus = sync_w[0];

  // transmit input resets to recessive like an open pin
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      txd_meta_reg <= 1'b1;
      txd_reg <= 1'b1;
    end else begin
      txd_meta_reg <= transmit_data_in_i;
      txd_reg <= txd_meta_reg;
    end
  end

  lnm_pkg::lnm_state_type state_reg, state_next;
  lnm_pkg::lnm_state_type prior_reg;
  logic en_d_reg;
  logic bus_d_reg;
  logic [lnm_pkg::CNT_W-1:0] wake_cnt_reg;
  logic [lnm_pkg::CNT_W-1:0] rst_cnt_reg;
  logic [lnm_pkg::CNT_W-1:0] fall_cnt_reg;
  logic reset_n_reg;
  logic [9:0] rx_cnt_reg;
  logic rx_reg;

  wire en_rise = cond.en & ~en_d_reg;
  wire en_fall = ~cond.en & en_d_reg;
  wire bus_edge = cond.bus ^ bus_d_reg;
  wire wake_hit = (wake_cnt_reg == lnm_pkg::CNT_W'(WAKE_TIME - 1));
  wire ready_out = (state_reg == lnm_pkg::LNM_NORMAL) && !cond.master_reset;
  wire reset_done = (rst_cnt_reg == lnm_pkg::CNT_W'(RESET_DELAY - 1));
  wire fall_done = (fall_cnt_reg == lnm_pkg::CNT_W'(lnm_pkg::RESET_FALL_CYCLES - 1));

  // mode transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lnm_pkg::LNM_POR: begin
        if (cond.supply_ok) state_next = lnm_pkg::LNM_INIT;
      end
      lnm_pkg::LNM_INIT: begin
        if (!cond.master_reset) state_next = lnm_pkg::LNM_NORMAL;
      end
      lnm_pkg::LNM_NORMAL: begin
        if (en_fall) state_next = lnm_pkg::LNM_SLEEP;
      end
      lnm_pkg::LNM_SLEEP: begin
        if (en_rise || wake_hit) state_next = lnm_pkg::LNM_INIT;
      end
      lnm_pkg::LNM_THERMAL: begin
        if (cond.under_recovery) begin
          state_next = (prior_reg == lnm_pkg::LNM_SLEEP) ? lnm_pkg::LNM_SLEEP
                                                         : lnm_pkg::LNM_INIT;
        end
      end
      default: state_next = lnm_pkg::LNM_POR;
    endcase
    // supply override from any state, temperature override from any state except por
    if (cond.supply_low) state_next = lnm_pkg::LNM_POR;
    else if (cond.over_temp && state_reg != lnm_pkg::LNM_POR)
      state_next = lnm_pkg::LNM_THERMAL;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_reg <= lnm_pkg::LNM_POR;
      prior_reg <= lnm_pkg::LNM_NORMAL;
      en_d_reg <= 1'b0;
      bus_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      en_d_reg <= cond.en;
      bus_d_reg <= cond.bus;
      if (state_next == lnm_pkg::LNM_THERMAL && state_reg != lnm_pkg::LNM_THERMAL)
        prior_reg <= (state_reg == lnm_pkg::LNM_SLEEP) ? lnm_pkg::LNM_SLEEP
                                                       : lnm_pkg::LNM_NORMAL;
    end
  end

  // bus pulse width counter, only live in sleep
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || state_reg != lnm_pkg::LNM_SLEEP || bus_edge)
      wake_cnt_reg <= lnm_pkg::CNT_ZERO;
    else if (!wake_hit)
      wake_cnt_reg <= wake_cnt_reg + 25'h0000001;
  end

  // reset output: delayed release and filtered fall
  wire out_good = cond.out_above_reset && state_reg == lnm_pkg::LNM_NORMAL;
  // por and init always present reset, even inside the fall filter window
  wire hold_low = state_reg == lnm_pkg::LNM_POR || state_reg == lnm_pkg::LNM_INIT;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rst_cnt_reg <= lnm_pkg::CNT_ZERO;
      fall_cnt_reg <= lnm_pkg::CNT_ZERO;
      reset_n_reg <= lnm_pkg::RESET_N_RST;
    end else if (!reset_n_reg) begin
      fall_cnt_reg <= lnm_pkg::CNT_ZERO;
      if (!out_good) rst_cnt_reg <= lnm_pkg::CNT_ZERO;
      else if (reset_done) reset_n_reg <= 1'b1;
      else rst_cnt_reg <= rst_cnt_reg + 25'h0000001;
    end else begin
      rst_cnt_reg <= lnm_pkg::CNT_ZERO;
      if (out_good) fall_cnt_reg <= lnm_pkg::CNT_ZERO;
      else if (fall_done || hold_low) reset_n_reg <= 1'b0;
      else fall_cnt_reg <= fall_cnt_reg + 25'h0000001;
    end
  end

  // receive spike filter: level must hold before it is passed on
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rx_reg <= 1'b1;
      rx_cnt_reg <= 10'h000;
    end else if (cond.bus == rx_reg) begin
      rx_cnt_reg <= 10'h000;
    end else if (rx_cnt_reg == 10'(lnm_pkg::RX_FILTER_CYCLES - 1)) begin
      rx_reg <= cond.bus;
      rx_cnt_reg <= 10'h000;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + 10'h001;
    end
  end

  // output gating
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      regulator_on_o <= 1'b0;
      transceiver_on_o <= 1'b0;
      bus_drive_dominant_o <= 1'b0;
      receive_data_out_o <= 1'b1;
      mode_o <= 3'h0;
    end else begin
      regulator_on_o <= state_reg == lnm_pkg::LNM_INIT || state_reg == lnm_pkg::LNM_NORMAL;
      transceiver_on_o <= ready_out;
      bus_drive_dominant_o <= ready_out && !txd_reg;
      receive_data_out_o <= rx_reg;
      mode_o <= 3'(state_reg);
    end
  end
  assign reset_n_o = reset_n_reg;

  // transmit never dominant outside normal with output up
  property p_tx_gate;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg != lnm_pkg::LNM_NORMAL) |=> !bus_drive_dominant_o;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("dominant outside normal");

  property p_sleep_entry;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == lnm_pkg::LNM_NORMAL && en_fall && !cond.supply_low && !cond.over_temp)
      |=> state_reg == lnm_pkg::LNM_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep on enable fall");

  property p_sleep_recessive;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == lnm_pkg::LNM_SLEEP) |=> !bus_drive_dominant_o && !regulator_on_o;
  endproperty
  a_sleep_recessive: assert property (p_sleep_recessive) else $error("bus not freed");

  property p_por_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      cond.supply_low |=> state_reg == lnm_pkg::LNM_POR;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por not held");

  property p_por_exit;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == lnm_pkg::LNM_POR && state_next != lnm_pkg::LNM_POR)
      |=> state_reg == lnm_pkg::LNM_INIT;
  endproperty
  a_por_exit: assert property (p_por_exit) else $error("por left other than to init");

  property p_thermal_off;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == lnm_pkg::LNM_THERMAL) |=> !transceiver_on_o && !regulator_on_o;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("active in shutdown");

  property p_reset_low_init;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == lnm_pkg::LNM_INIT) |=> !reset_n_o;
  endproperty
  a_reset_low_init: assert property (p_reset_low_init) else $error("reset high in init");

  property p_reset_rise;
    @(posedge clock_i) disable iff (!rst_b_i)
      $rose(reset_n_o) |-> $past(reset_done) && $past(out_good);
  endproperty
  a_reset_rise: assert property (p_reset_rise) else $error("reset released early");

  property p_wake;
    @(posedge clock_i) disable iff (!rst_b_i)
      (state_reg == lnm_pkg::LNM_SLEEP && wake_hit && !cond.supply_low && !cond.over_temp)
      |=> state_reg == lnm_pkg::LNM_INIT;
  endproperty
  a_wake: assert property (p_wake) else $error("bus wake missed");
endmodule

// *** common/lnm_pkg.sv ***
// package for the lin node mode controller: timing constants and state type
// assumes a single 200 MHz clock
package lnm_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned WAKE_PULSE_US = 60;
  localparam int unsigned WAKE_CYCLES = WAKE_PULSE_US * CLK_MHZ;
  localparam int unsigned RESET_DELAY_MS = 100;
  localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned RX_FILTER_NS = 2800;
  localparam int unsigned RX_FILTER_CYCLES = (RX_FILTER_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESET_FALL_NS = 10000;
  localparam int unsigned RESET_FALL_CYCLES = (RESET_FALL_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 25;
  localparam logic [24:0] CNT_ZERO = 25'h0000000;
  localparam logic RESET_N_RST = 1'b0;
  typedef enum logic [2:0] {
    LNM_POR, LNM_INIT, LNM_NORMAL, LNM_SLEEP, LNM_THERMAL
  } lnm_state_type;
endpackage

// *** common/lnm_cond_if.sv ***
// interface carrying synchronised analogue indications to the mode logic
// assumes all members are on clock_i
`timescale 1ns/1ps
interface lnm_cond_if;
  logic supply_low;
  logic supply_ok;
  logic master_reset;
  logic out_above_reset;
  logic over_temp;
  logic under_recovery;
  logic en;
  logic bus;
  modport src (output supply_low, supply_ok, master_reset, out_above_reset, over_temp,
    under_recovery, en, bus);
  modport dst (input supply_low, supply_ok, master_reset, out_above_reset, over_temp,
    under_recovery, en, bus);
endinterface

// *** src/lnm_sync.sv ***
// two-flop synchronisers for every asynchronous indication and the enable and bus pins
// assumes inputs come from comparators or pins outside the clock domain
`timescale 1ns/1ps
module lnm_sync #(
  parameter int unsigned N = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // raw levels
  input wire logic [N-1:0] raw_i,
  // synchronised levels
  output logic [N-1:0] sync_o
);
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw_i;
      sync_reg <= meta_reg;
    end
  end
  assign sync_o = sync_reg;
endmodule

// *** tb/lnm_lin_ctrl_model.sv ***
// partner: lin protocol controller sending short frames and sampling rxd mid-bit
// assumes rxd loops back from the bus through the mode controller
`timescale 1ns/1ps
module lnm_lin_ctrl_model #(
  parameter int unsigned BIT_CYC = 10000,
  parameter int unsigned NB = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // frame request
  input wire logic start_i,
  input wire logic [NB-1:0] data_i,
  input wire logic rxd_i,
  // transmit and results
  output logic txd_o,
  output logic busy_o,
  output logic [NB-1:0] rx_o
);
  logic [31:0] cyc_reg;
  logic [7:0] bit_reg;
  logic [NB+1:0] sh_reg;
  assign txd_o = busy_o ? sh_reg[0] : 1'b1;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      busy_o <= 1'b0;
      cyc_reg <= 32'h0;
      bit_reg <= 8'h0;
      sh_reg <= '1;
      rx_o <= '0;
    end else if (!busy_o && start_i) begin
      busy_o <= 1'b1;
      sh_reg <= {1'b1, data_i, 1'b0};
      cyc_reg <= 32'h0;
      bit_reg <= 8'h0;
    end else if (busy_o) begin
      if (cyc_reg == BIT_CYC / 2 && bit_reg >= 8'h1 && bit_reg <= 8'(NB)) begin
        rx_o <= {rxd_i, rx_o[NB-1:1]};
      end
      // one bit per 50 us keeps to the 20 kb ceiling
      if (cyc_reg == BIT_CYC - 1) begin
        cyc_reg <= 32'h0;
        bit_reg <= bit_reg + 8'h1;
        sh_reg <= {1'b1, sh_reg[NB+1:1]};
        busy_o <= (bit_reg != 8'(NB + 1));
      end else begin
        cyc_reg <= cyc_reg + 32'h1;
      end
    end
  end
endmodule

// *** tb/tb.sv ***
// testbench for the lin node mode controller with a simple regulator model
// assumes short reset delay and wake time parameters
`timescale 1ns/1ps
module tb;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic supply_low = 1'b1, supply_ok = 1'b0, temp_hi = 1'b0, temp_ok = 1'b1;
  logic en = 1'b0, ext_bus = 1'b1, noise = 1'b0, start = 1'b0;
  logic [2:0] data = 3'h0;
  logic [3:0] vcnt = 4'h0, ncnt = 4'h0;
  logic reg_on, xcvr_on, dom, rxd, rst_n, txd, busy, bus;
  logic [2:0] mode, rx;
  int fail_count = 0, num_checks = 0, seed = 59525, w;
  // noise toggles every 8 cycles so a sleeping node sees no long level
  assign bus = ~dom & (noise ? ncnt[3] : ext_bus);
  initial forever #2.5 clock_i = ~clock_i;
  // regulator output ramps while switched on
  always_ff @(posedge clock_i) begin
    ncnt <= ncnt + 4'h1;
    if (!reg_on) vcnt <= 4'h0;
    else if (vcnt != 4'hA) vcnt <= vcnt + 4'h1;
  end
  lnm_mode_ctrl #(.RESET_DELAY(50), .WAKE_TIME(20)) u_lnm_mode_ctrl (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .supply_below_on_i(supply_low),
    .supply_above_off_i(supply_ok), .out_below_master_reset_i(vcnt < 4'h5),
    .out_above_reset_thr_i(vcnt == 4'hA), .temp_above_shutdown_i(temp_hi),
    .temp_below_recovery_i(temp_ok), .enable_i(en), .bus_level_i(bus),
    .transmit_data_in_i(txd), .regulator_on_o(reg_on), .transceiver_on_o(xcvr_on),
    .bus_drive_dominant_o(dom), .receive_data_out_o(rxd), .reset_n_o(rst_n),
    .mode_o(mode));
  lnm_lin_ctrl_model u_lnm_lin_ctrl_model (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start), .data_i(data),
    .rxd_i(rxd), .txd_o(txd), .busy_o(busy), .rx_o(rx));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    int i;
    for (i = 0; i < lim && mode !== m; i++) step(1);
    check(mode, m, "mode not reached");
    if (mode !== m) report_and_stop();
  endtask
  initial begin
    step(6);
    rst_b_i = 1'b1;
    en = 1'($random(seed));
    step(20);
    check(mode, lnm_pkg::LNM_POR, "por left early");
    supply_low = 1'b0;
    supply_ok = 1'b1;
    wait_mode(lnm_pkg::LNM_NORMAL, 100);
    check(xcvr_on, 1'b1, "transceiver off");
    step(20);
    check(rst_n, 1'b0, "reset released early");
    step(60);
    check(rst_n, 1'b1, "reset not released");
    $display("test power_up done");
    ext_bus = 1'b0;
    step(200);
    check(rxd, 1'b1, "spike passed");
    step(600);
    check(rxd, 1'b0, "bus low not seen");
    ext_bus = 1'b1;
    en = 1'b1;
    step(800);
    wait_mode(lnm_pkg::LNM_NORMAL, 100);
    data = 3'($random(seed));
    start = 1'b1;
    step(1);
    start = 1'b0;
    for (w = 0; w < 60000 && busy; w++) step(1);
    check(busy, 1'b0, "frame never ended");
    check(rx, data, "loopback frame");
    start = 1'b1;
    step(100);
    start = 1'b0;
    check(dom, 1'b1, "start bit not dominant");
    noise = 1'b1;
    en = 1'b0;
    wait_mode(lnm_pkg::LNM_SLEEP, 50);
    step(2);
    check(dom, 1'b0, "dominant kept in sleep");
    check(reg_on, 1'b0, "regulator on in sleep");
    repeat (3) begin
      ext_bus = ~ncnt[3];
      noise = 1'b0;
      step(1 + ($random(seed) & 7));
      noise = 1'b1;
      step(30);
      check(mode, lnm_pkg::LNM_SLEEP, "short pulse woke");
    end
    noise = 1'b0;
    ext_bus = 1'b0;
    wait_mode(lnm_pkg::LNM_NORMAL, 200);
    ext_bus = 1'b1;
    step(200);
    check(mode, lnm_pkg::LNM_NORMAL, "slept without enable");
    en = 1'b1;
    step(50);
    noise = 1'b1;
    en = 1'b0;
    wait_mode(lnm_pkg::LNM_SLEEP, 50);
    en = 1'b1;
    wait_mode(lnm_pkg::LNM_NORMAL, 100);
    en = 1'b0;
    wait_mode(lnm_pkg::LNM_SLEEP, 50);
    $display("test sleep_wake done");
    supply_low = 1'b1;
    supply_ok = 1'b0;
    wait_mode(lnm_pkg::LNM_POR, 20);
    supply_low = 1'b0;
    supply_ok = 1'b1;
    wait_mode(lnm_pkg::LNM_NORMAL, 100);
    step(100);
    temp_hi = 1'b1;
    temp_ok = 1'b0;
    wait_mode(lnm_pkg::LNM_THERMAL, 20);
    check(xcvr_on, 1'b0, "transceiver on in shutdown");
    en = 1'b1;
    step(500);
    check(mode, lnm_pkg::LNM_THERMAL, "local wake in shutdown");
    check(rst_n, 1'b1, "reset fell early");
    step(1700);
    check(rst_n, 1'b0, "reset not fallen");
    temp_hi = 1'b0;
    temp_ok = 1'b1;
    wait_mode(lnm_pkg::LNM_NORMAL, 100);
    en = 1'b0;
    wait_mode(lnm_pkg::LNM_SLEEP, 50);
    temp_hi = 1'b1;
    temp_ok = 1'b0;
    wait_mode(lnm_pkg::LNM_THERMAL, 20);
    check(reg_on, 1'b0, "regulator on in shutdown");
    temp_hi = 1'b0;
    temp_ok = 1'b1;
    wait_mode(lnm_pkg::LNM_SLEEP, 20);
    step(20);
    check(mode, lnm_pkg::LNM_SLEEP, "woke after shutdown");
    $display("test supply_thermal done");
    report_and_stop();
  end
endmodule
